// ### hw/pmtr_top.sv
// program memory, instruction fetch, table read path and programming access
// assumes a core that issues table reads and jumps in step with PHASE_O
`timescale 1ns/1ps
module pmtr_top #(
	parameter int WORDS = pmtr_pkg::PMTR_WORDS_DEF
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	output pmtr_pkg::pmtr_phase_t PHASE_O,
	input wire logic PC_LOAD_I,
	input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] PC_LOAD_ADDR_I,
	output logic [pmtr_pkg::PMTR_ADDR_W-1:0] PC_O,
	output logic [pmtr_pkg::PMTR_WORD_W-1:0] INSTR_O,
	output logic INSTR_VALID_O,
	input wire logic TBL_REQ_I,
	input wire pmtr_pkg::pmtr_tbl_req_t TBL_REQ_DATA_I,
	output logic TBL_BUSY_O,
	output logic TBL_DONE_O,
	output logic DM_WE_O,
	output pmtr_pkg::pmtr_dm_wr_t DM_WR_O,
	input wire logic TABLE_HIGH_BYTE_LATCH_WE_I,
	input wire logic [7:0] TABLE_HIGH_BYTE_LATCH_WDATA_I,
	output logic [7:0] TABLE_HIGH_BYTE_LATCH_O,
	input wire logic PROG_MODE_I,
	input wire logic PROG_SERIAL_CLOCK_PIN_I,
	input wire logic PROG_SERIAL_DATA_PIN_I,
	output logic PROG_SERIAL_DATA_PIN_O,
	output logic PROG_SERIAL_DATA_PIN_OE_O,
	output logic EE_WE_O,
	output logic EE_RE_O,
	output logic [15:0] EE_ADDR_O,
	output logic [7:0] EE_WDATA_O,
	input wire logic [7:0] EE_RDATA_I
);
	import pmtr_pkg::*;

	typedef enum logic [1:0] {
		PMTR_TS_IDLE = 2'b00,
		PMTR_TS_CYC1 = 2'b01,
		PMTR_TS_CYC2 = 2'b10
	} pmtr_tbl_state_t;

	localparam int AW = $clog2(WORDS);

	// last-page forms drop the high pointer byte
	function automatic logic is_last_page(input pmtr_tbl_kind_t k);
		return (k == PMTR_TBL_STD_LAST) || (k == PMTR_TBL_EXT_LAST);
	endfunction

	// only the extended forms may name a sector other than zero
	function automatic logic is_extended(input pmtr_tbl_kind_t k);
		return (k == PMTR_TBL_EXT) || (k == PMTR_TBL_EXT_LAST);
	endfunction

	// table word address from pointer pair; last page ignores the high byte
	function automatic logic [PMTR_ADDR_W-1:0] tbl_addr(input pmtr_tbl_req_t r);
		logic [PMTR_ADDR_W-1:0] a;
		a = PMTR_ADDR_W'({r.tbhp, r.tblp});
		if (is_last_page(r.kind))
			a = PMTR_ADDR_W'({{(PMTR_ADDR_W-8){1'b1}}, r.tblp}) & PMTR_ADDR_W'(WORDS - 1);
		return a;
	endfunction

	logic [PMTR_WORD_W-1:0] mem [WORDS];
	pmtr_phase_t phase_q;
	logic [PMTR_ADDR_W-1:0] pc_q;
	logic [PMTR_ADDR_W-1:0] rd_addr;
	logic [PMTR_WORD_W-1:0] rdata_q;
	logic [PMTR_WORD_W-1:0] instr_q;
	logic instr_valid_q;
	logic fetch_en;
	logic tbl_finish;
	pmtr_tbl_state_t tbl_state_q;
	pmtr_tbl_req_t tbl_req_q;
	logic [PMTR_WORD_W-1:0] tbl_word_q;
	logic tbl_done_q;
	logic dm_we_q;
	pmtr_dm_wr_t dm_wr_q;
	logic [7:0] table_high_byte_latch_q;
	pmtr_icp_req_t icp_req;
	logic icp_req_valid;
	pmtr_icp_req_t icp_q;
	logic icp_pm_rd_q;
	logic icp_pm_wr_q;
	logic icp_pm_arm_q;
	logic icp_ee_rd_q;
	logic icp_rsp_valid_q;
	logic [15:0] icp_rsp_q;
	logic ee_we_q;
	logic ee_re_q;
	logic [15:0] ee_addr_q;
	logic [7:0] ee_wdata_q;

	// four phase sequencer; one full turn is one instruction cycle
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			phase_q <= PMTR_PH_T1;
		else
			phase_q <= pmtr_phase_t'(phase_q + 2'h1);
	end

	// a held fetch keeps the next instruction from being lost or doubled
	assign fetch_en = (phase_q == PMTR_PH_T1) && (tbl_state_q != PMTR_TS_CYC2);

	// write-back edge: the T4 that closes the second cycle of a table read
	assign tbl_finish = (tbl_state_q == PMTR_TS_CYC2) && (phase_q == PMTR_PH_T4);

	// program counter: advances at T1, jumps taken at T4
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pc_q <= PMTR_RESET_VECTOR;
		end else if (phase_q == PMTR_PH_T4 && PC_LOAD_I) begin
			pc_q <= PC_LOAD_ADDR_I & PMTR_ADDR_W'(WORDS - 1);
		end else if (fetch_en) begin
			pc_q <= (pc_q + 15'h0001) & PMTR_ADDR_W'(WORDS - 1);
		end
	end

	// single read port shared by phase: fetch at T1, table at T2, programming at T3
	// one phase per user; only fetch waits on another, held through the second cycle of a table read
	always_comb begin
		case (phase_q)
		PMTR_PH_T1: rd_addr = pc_q;
		PMTR_PH_T2: rd_addr = tbl_addr(tbl_req_q);
		PMTR_PH_T3: rd_addr = icp_q.addr[PMTR_ADDR_W-1:0];
		default: rd_addr = pc_q;
		endcase
	end

	// registered read port; the phase owner finds its word one cycle on
	always_ff @(posedge SYS_CLK_I) begin
		rdata_q <= mem[rd_addr[AW-1:0]];
	end

	// array has no reset; flash contents only change by programming at T4
	always_ff @(posedge SYS_CLK_I) begin
		if (phase_q == PMTR_PH_T4 && icp_pm_wr_q)
			mem[icp_q.addr[AW-1:0]] <= icp_q.wdata;
	end

	// fetched word is presented in T2 with a one cycle valid pulse
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			instr_q <= 16'h0000;
			instr_valid_q <= 1'b0;
		end else begin
			instr_valid_q <= fetch_en;
			if (fetch_en)
				instr_q <= mem[pc_q[AW-1:0]];
		end
	end

	// table read sequencer: request taken at T1, result lands at T4 of cycle two
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tbl_state_q <= PMTR_TS_IDLE;
			tbl_req_q <= '0;
			tbl_word_q <= 16'h0000;
		end else begin
			if (phase_q == PMTR_PH_T3 && tbl_state_q == PMTR_TS_CYC1)
				tbl_word_q <= rdata_q;
			case (tbl_state_q)
			PMTR_TS_IDLE: begin
				if (phase_q == PMTR_PH_T1 && TBL_REQ_I) begin
					tbl_req_q <= TBL_REQ_DATA_I;
					tbl_state_q <= PMTR_TS_CYC1;
				end
			end
			PMTR_TS_CYC1: begin
				if (phase_q == PMTR_PH_T4)
					tbl_state_q <= PMTR_TS_CYC2;
			end
			PMTR_TS_CYC2: begin
				if (phase_q == PMTR_PH_T4)
					tbl_state_q <= PMTR_TS_IDLE;
			end
			default: tbl_state_q <= PMTR_TS_IDLE;
			endcase
		end
	end

	// low byte to data memory; standard forms are pinned to sector zero
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			dm_we_q <= 1'b0;
			dm_wr_q <= '0;
			tbl_done_q <= 1'b0;
		end else begin
			dm_we_q <= 1'b0;
			tbl_done_q <= 1'b0;
			if (tbl_finish) begin
				dm_we_q <= 1'b1;
				tbl_done_q <= 1'b1;
				dm_wr_q.offset <= tbl_req_q.offset;
				dm_wr_q.data <= tbl_word_q[7:0];
				if (!is_extended(tbl_req_q.kind))
					dm_wr_q.sector <= PMTR_SECTOR_ZERO;
				else
					dm_wr_q.sector <= tbl_req_q.sector;
			end
		end
	end

	// high-byte latch; a finishing table read wins over a software write
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			table_high_byte_latch_q <= PMTR_TABLE_HIGH_BYTE_LATCH_RESET;
		else if (tbl_finish)
			table_high_byte_latch_q <= tbl_word_q[15:8];
		else if (TABLE_HIGH_BYTE_LATCH_WE_I)
			table_high_byte_latch_q <= TABLE_HIGH_BYTE_LATCH_WDATA_I;
	end

	pmtr_prog_serial u_serial (
		.clk_i(SYS_CLK_I),
		.rst_b_i(RST_B_I),
		.prog_mode_i(PROG_MODE_I),
		.prog_serial_clock_pin_i(PROG_SERIAL_CLOCK_PIN_I),
		.prog_serial_data_pin_i(PROG_SERIAL_DATA_PIN_I),
		.prog_serial_data_pin_o(PROG_SERIAL_DATA_PIN_O),
		.prog_serial_data_pin_oe_o(PROG_SERIAL_DATA_PIN_OE_O),
		.req_o(icp_req),
		.req_valid_o(icp_req_valid),
		.rsp_data_i(icp_rsp_q),
		.rsp_valid_i(icp_rsp_valid_q)
	);

	// programming requests: program memory waits for its phase slot,
	// nonvolatile data memory goes straight out
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			icp_q <= '0;
			icp_pm_rd_q <= 1'b0;
			icp_pm_wr_q <= 1'b0;
			icp_pm_arm_q <= 1'b0;
			icp_ee_rd_q <= 1'b0;
			icp_rsp_valid_q <= 1'b0;
			icp_rsp_q <= 16'h0000;
			ee_we_q <= 1'b0;
			ee_re_q <= 1'b0;
			ee_addr_q <= 16'h0000;
			ee_wdata_q <= 8'h00;
		end else begin
			icp_rsp_valid_q <= 1'b0;
			ee_we_q <= 1'b0;
			ee_re_q <= 1'b0;
			icp_ee_rd_q <= ee_re_q;
			if (icp_req_valid) begin
				icp_q <= icp_req;
				icp_pm_arm_q <= 1'b0;
				icp_pm_rd_q <= (icp_req.cmd == PMTR_CMD_PM_READ);
				icp_pm_wr_q <= (icp_req.cmd == PMTR_CMD_PM_WRITE);
				ee_addr_q <= icp_req.addr;
				ee_wdata_q <= icp_req.wdata[7:0];
				ee_we_q <= (icp_req.cmd == PMTR_CMD_EE_WRITE);
				ee_re_q <= (icp_req.cmd == PMTR_CMD_EE_READ);
			end else if (phase_q == PMTR_PH_T3) begin
				// a request landing on a T3 edge missed that read slot; wait one turn
				icp_pm_arm_q <= icp_pm_rd_q;
			end else if (phase_q == PMTR_PH_T4) begin
				icp_pm_wr_q <= 1'b0;
				if (icp_pm_rd_q && icp_pm_arm_q) begin
					icp_pm_rd_q <= 1'b0;
					icp_pm_arm_q <= 1'b0;
					icp_rsp_q <= rdata_q;
					icp_rsp_valid_q <= 1'b1;
				end
			end
			if (icp_ee_rd_q) begin
				icp_rsp_q <= {8'h00, EE_RDATA_I};
				icp_rsp_valid_q <= 1'b1;
			end
		end
	end

	assign PHASE_O = phase_q;
	assign PC_O = pc_q;
	assign INSTR_O = instr_q;
	assign INSTR_VALID_O = instr_valid_q;
	assign TBL_BUSY_O = (tbl_state_q != PMTR_TS_IDLE);
	assign TBL_DONE_O = tbl_done_q;
	assign DM_WE_O = dm_we_q;
	assign DM_WR_O = dm_wr_q;
	assign TABLE_HIGH_BYTE_LATCH_O = table_high_byte_latch_q;
	assign EE_WE_O = ee_we_q;
	assign EE_RE_O = ee_re_q;
	assign EE_ADDR_O = ee_addr_q;
	assign EE_WDATA_O = ee_wdata_q;

endmodule

// ### hw/pmtr_pkg.sv
// constants, field layouts and carrier types for the program memory access path
// assumes a 125 MHz system clock divided into four phases per instruction cycle
package pmtr_pkg;

	// program memory geometry
	localparam int PMTR_WORD_W = 16;
	localparam int PMTR_ADDR_W = 15;
	localparam int PMTR_WORDS_DEF = 16384;
	localparam logic [PMTR_ADDR_W-1:0] PMTR_RESET_VECTOR = 15'h0000;
	localparam int PMTR_BYTE_W = 8;

	// data memory destination layout
	localparam int PMTR_SECTOR_W = 3;
	localparam logic [PMTR_SECTOR_W-1:0] PMTR_SECTOR_ZERO = 3'h0;

	// instruction cycle timing
	localparam int PMTR_SYS_PERIOD_NS = 8;
	localparam int PMTR_PHASES = 4;
	localparam int PMTR_TBL_CYCLES = 2;
	localparam logic [PMTR_BYTE_W-1:0] PMTR_TABLE_HIGH_BYTE_LATCH_RESET = 8'h00;

	// serial programming frame
	localparam int PMTR_CMD_W = 4;
	localparam int PMTR_HDR_W = 20;
	localparam int PMTR_DATA_BITS = 16;
	localparam logic [3:0] PMTR_CMD_PM_WRITE = 4'h1;
	localparam logic [3:0] PMTR_CMD_PM_READ = 4'h2;
	localparam logic [3:0] PMTR_CMD_EE_WRITE = 4'h3;
	localparam logic [3:0] PMTR_CMD_EE_READ = 4'h4;

	// internal phases of one instruction cycle
	typedef enum logic [1:0] {
		PMTR_PH_T1 = 2'b00,
		PMTR_PH_T2 = 2'b01,
		PMTR_PH_T3 = 2'b10,
		PMTR_PH_T4 = 2'b11
	} pmtr_phase_t;

	// table read flavours
	typedef enum logic [1:0] {
		PMTR_TBL_STD = 2'b00,
		PMTR_TBL_STD_LAST = 2'b01,
		PMTR_TBL_EXT = 2'b10,
		PMTR_TBL_EXT_LAST = 2'b11
	} pmtr_tbl_kind_t;

	typedef struct packed {
		pmtr_tbl_kind_t kind;
		logic [PMTR_SECTOR_W-1:0] sector;
		logic [7:0] offset;
		logic [7:0] tblp;
		logic [7:0] tbhp;
	} pmtr_tbl_req_t;

	typedef struct packed {
		logic [PMTR_SECTOR_W-1:0] sector;
		logic [7:0] offset;
		logic [7:0] data;
	} pmtr_dm_wr_t;

	typedef struct packed {
		logic [PMTR_CMD_W-1:0] cmd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} pmtr_icp_req_t;

endpackage

// ### hw/pmtr_prog_serial.sv
// serial programming engine: one data pin both ways, clocked by the writer
// assumes writer clock much slower than the system clock; pins are asynchronous
`timescale 1ns/1ps
module pmtr_prog_serial (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic prog_mode_i,
	input wire logic prog_serial_clock_pin_i,
	input wire logic prog_serial_data_pin_i,
	output logic prog_serial_data_pin_o,
	output logic prog_serial_data_pin_oe_o,
	output pmtr_pkg::pmtr_icp_req_t req_o,
	output logic req_valid_o,
	input wire logic [15:0] rsp_data_i,
	input wire logic rsp_valid_i
);
	import pmtr_pkg::*;

	typedef enum logic [1:0] {
		PMTR_SER_HDR = 2'b00,
		PMTR_SER_WDATA = 2'b01,
		PMTR_SER_RWAIT = 2'b10,
		PMTR_SER_RDATA = 2'b11
	} pmtr_ser_state_t;

	logic [2:0] ck_sync_q;
	logic [2:0] da_sync_q;
	logic ck_lvl_q;
	logic da_lvl_q;
	logic ck_rise;
	logic ck_fall;
	pmtr_ser_state_t state_q;
	logic [4:0] cnt_q;
	logic [PMTR_HDR_W-1:0] hdr_q;
	logic [15:0] sh_q;
	logic out_q;
	logic oe_q;
	logic req_valid_q;
	pmtr_icp_req_t req_q;

	// three stages; a change only counts once stages two and three agree
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ck_sync_q <= 3'h0;
			da_sync_q <= 3'h0;
			ck_lvl_q <= 1'b0;
			da_lvl_q <= 1'b0;
		end else begin
			ck_sync_q <= {ck_sync_q[1:0], prog_serial_clock_pin_i};
			da_sync_q <= {da_sync_q[1:0], prog_serial_data_pin_i};
			if (ck_sync_q[1] == ck_sync_q[2])
				ck_lvl_q <= ck_sync_q[2];
			if (da_sync_q[1] == da_sync_q[2])
				da_lvl_q <= da_sync_q[2];
		end
	end

	assign ck_rise = (ck_sync_q[1] == ck_sync_q[2]) && ck_sync_q[2] && !ck_lvl_q;
	assign ck_fall = (ck_sync_q[1] == ck_sync_q[2]) && !ck_sync_q[2] && ck_lvl_q;

	// frame engine: writer samples on rise, device drives on fall, msb first
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= PMTR_SER_HDR;
			cnt_q <= 5'h00;
			hdr_q <= '0;
			sh_q <= 16'h0000;
			out_q <= 1'b0;
			oe_q <= 1'b0;
			req_valid_q <= 1'b0;
			req_q <= '0;
		end else begin
			req_valid_q <= 1'b0;
			if (!prog_mode_i) begin
				// leaving programming mode abandons any half frame
				state_q <= PMTR_SER_HDR;
				cnt_q <= 5'h00;
				oe_q <= 1'b0;
			end else begin
				case (state_q)
				PMTR_SER_HDR: begin
					if (ck_rise) begin
						hdr_q <= {hdr_q[PMTR_HDR_W-2:0], da_lvl_q};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == 5'(PMTR_HDR_W - 1)) begin
							cnt_q <= 5'h00;
							req_q.cmd <= hdr_q[PMTR_HDR_W-2:15];
							req_q.addr <= {hdr_q[14:0], da_lvl_q};
							if (hdr_q[PMTR_HDR_W-2:15] == PMTR_CMD_PM_READ ||
								hdr_q[PMTR_HDR_W-2:15] == PMTR_CMD_EE_READ) begin
								req_valid_q <= 1'b1;
								state_q <= PMTR_SER_RWAIT;
							end else begin
								state_q <= PMTR_SER_WDATA;
							end
						end
					end
				end
				PMTR_SER_WDATA: begin
					if (ck_rise) begin
						sh_q <= {sh_q[14:0], da_lvl_q};
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == 5'(PMTR_DATA_BITS - 1)) begin
							cnt_q <= 5'h00;
							req_q.wdata <= {sh_q[14:0], da_lvl_q};
							req_valid_q <= 1'b1;
							state_q <= PMTR_SER_HDR;
						end
					end
				end
				PMTR_SER_RWAIT: begin
					if (rsp_valid_i) begin
						sh_q <= {rsp_data_i[14:0], 1'b0};
						out_q <= rsp_data_i[15];
						oe_q <= 1'b1;
						state_q <= PMTR_SER_RDATA;
					end
				end
				PMTR_SER_RDATA: begin
					if (ck_fall) begin
						cnt_q <= cnt_q + 5'h01;
						if (cnt_q == 5'(PMTR_DATA_BITS - 1)) begin
							cnt_q <= 5'h00;
							oe_q <= 1'b0;
							state_q <= PMTR_SER_HDR;
						end else begin
							out_q <= sh_q[15];
							sh_q <= {sh_q[14:0], 1'b0};
						end
					end
				end
				default: state_q <= PMTR_SER_HDR;
				endcase
			end
		end
	end

	assign prog_serial_data_pin_o = out_q;
	assign prog_serial_data_pin_oe_o = oe_q;
	assign req_o = req_q;
	assign req_valid_o = req_valid_q;

endmodule

// ### tb/pmtr_top_asserts.sv
// timing checks on fetch, table read and programming pin of pmtr_top
// sees top ports only; bound in from the testbench file
`timescale 1ns/1ps
module pmtr_top_asserts (
	input wire logic SYS_CLK_I,
	input wire logic RST_B_I,
	input wire pmtr_pkg::pmtr_phase_t PHASE_O,
	input wire logic PC_LOAD_I,
	input wire logic [pmtr_pkg::PMTR_ADDR_W-1:0] PC_O,
	input wire logic INSTR_VALID_O,
	input wire logic TBL_REQ_I,
	input wire pmtr_pkg::pmtr_tbl_req_t TBL_REQ_DATA_I,
	input wire logic TBL_BUSY_O,
	input wire logic TBL_DONE_O,
	input wire logic DM_WE_O,
	input wire pmtr_pkg::pmtr_dm_wr_t DM_WR_O,
	input wire logic TABLE_HIGH_BYTE_LATCH_WE_I,
	input wire logic [7:0] TABLE_HIGH_BYTE_LATCH_WDATA_I,
	input wire logic [7:0] TABLE_HIGH_BYTE_LATCH_O,
	input wire logic PROG_MODE_I,
	input wire logic PROG_SERIAL_DATA_PIN_OE_O
);
	import pmtr_pkg::*;
	logic take;
	pmtr_tbl_req_t req_q;
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_B_I);
	// request accepted only at T1 while idle
	assign take = TBL_REQ_I && PHASE_O == PMTR_PH_T1 && !TBL_BUSY_O;
	// keep the accepted request; the write-back is judged against it
	always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			req_q <= '0;
		end else if (take) begin
			req_q <= TBL_REQ_DATA_I;
		end
	end
	a_phase_steps: assert property (1'b1 |=> PHASE_O == pmtr_phase_t'($past(PHASE_O) + 2'h1))
		else $error("phase out of order");
	a_pc_still: assert property (PHASE_O != PMTR_PH_T1 && !(PHASE_O == PMTR_PH_T4 && PC_LOAD_I)
		|=> $stable(PC_O)) else $error("pc moved off T1");
	a_fetch_runs: assert property (PHASE_O == PMTR_PH_T1 && !TBL_BUSY_O && !PROG_MODE_I
		|=> INSTR_VALID_O) else $error("fetch missing");
	a_fetch_held: assert property (PHASE_O == PMTR_PH_T1 && TBL_BUSY_O
		|=> !INSTR_VALID_O && $stable(PC_O)) else $error("fetch during table cycle two");
	a_tbl_cycles: assert property (take
		|=> (TBL_BUSY_O && !DM_WE_O) [*7] ##1 (DM_WE_O && TBL_DONE_O)) else $error("table length");
	a_std_sector: assert property (DM_WE_O && !req_q.kind[1] |-> DM_WR_O.sector == PMTR_SECTOR_ZERO)
		else $error("standard read left sector 0");
	a_ext_sector: assert property (DM_WE_O && req_q.kind[1] |-> DM_WR_O.sector == req_q.sector)
		else $error("extended sector wrong");
	a_low_dest: assert property (DM_WE_O |-> DM_WR_O.offset == req_q.offset)
		else $error("destination offset wrong");
	a_table_high_byte_latch_write: assert property (TABLE_HIGH_BYTE_LATCH_WE_I && !TBL_BUSY_O |=> TABLE_HIGH_BYTE_LATCH_O == $past(TABLE_HIGH_BYTE_LATCH_WDATA_I))
		else $error("latch write lost");
	a_table_high_byte_latch_cause: assert property ($changed(TABLE_HIGH_BYTE_LATCH_O) |-> $past(TABLE_HIGH_BYTE_LATCH_WE_I) || TBL_DONE_O)
		else $error("latch changed unasked");
	a_oe_abort: assert property (!PROG_MODE_I [*3] |-> !PROG_SERIAL_DATA_PIN_OE_O)
		else $error("pin driven outside mode");
	c_ext_last: cover property (take && TBL_REQ_DATA_I.kind == PMTR_TBL_EXT_LAST);
	c_back_to_back: cover property (DM_WE_O && take);
	c_pin_turn: cover property ($rose(PROG_SERIAL_DATA_PIN_OE_O));
endmodule

// ### tb/pmtr_writer_model.sv
// writer model for the serial programming pins
// called at falling system clock edges; writer clock idles low between frames
`timescale 1ns/1ps
module pmtr_writer_model (
	input wire logic clk_i,
	input wire logic pin_i,
	output logic ck_o,
	output logic da_o
);
	import pmtr_pkg::*;
	localparam int HALF = 5;
	// still clock outside frames
	initial begin
		ck_o = 1'b0;
		da_o = 1'b0;
	end
	// data changes while low; the device takes it on the rise
	task automatic bit_out(input logic b);
		ck_o = 1'b0;
		da_o = b;
		repeat (HALF) @(negedge clk_i);
		ck_o = 1'b1;
		repeat (HALF) @(negedge clk_i);
	endtask
	// whole frame msb first; reads hand the pin to the device
	task automatic frame(input logic [3:0] cmd, input logic [15:0] addr,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [35:0] f;
		f = {cmd, addr, wd};
		rd = 16'h0000;
		for (int i = 35; i >= 16; i--) bit_out(f[i]);
		if (cmd == PMTR_CMD_PM_READ || cmd == PMTR_CMD_EE_READ) begin
			da_o = ~da_o; // released: no stale level to hide a dead driver
			repeat (16) @(negedge clk_i);
			rd[15] = pin_i;
			for (int i = 14; i >= 0; i--) begin
				ck_o = 1'b0;
				repeat (8) @(negedge clk_i);
				rd[i] = pin_i;
				ck_o = 1'b1;
				repeat (HALF) @(negedge clk_i);
			end
		end else begin
			for (int i = 15; i >= 0; i--) bit_out(f[i]);
		end
		ck_o = 1'b0;
		repeat (16) @(negedge clk_i);
	endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for pmtr_top: programming, table reads, fetch
// program memory starts unwritten, so every word read is first written
`timescale 1ns/1ps
module testbench;
	import pmtr_pkg::*;
	localparam int WORDS = 16384;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic pc_load = 1'b0;
	logic [14:0] pc_addr = 15'h0000;
	logic tbl_req = 1'b0;
	pmtr_tbl_req_t tbl_data = '0;
	logic th_we = 1'b0;
	logic [7:0] th_wd = 8'h00;
	logic prog = 1'b0;
	logic [7:0] ee_rd = 8'h00;
	logic sck, sda, pin, dout, oe, ivalid, busy, done, dm_we, ee_we, ee_re;
	pmtr_phase_t phase;
	logic [14:0] pc;
	logic [15:0] instr, ee_addr;
	logic [7:0] table_high_byte_latch, ee_wd;
	pmtr_dm_wr_t dm_wr;
	logic [15:0] mem [int];
	logic [26:0] expq [$];
	int fails = 0;
	int checks = 0;
	int cycles = 0;
	always #4 clk = ~clk;
	// the pin carries whoever drives it
	assign pin = oe ? dout : sda;
	pmtr_top #(.WORDS(WORDS)) dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .PHASE_O(phase),
		.PC_LOAD_I(pc_load), .PC_LOAD_ADDR_I(pc_addr), .PC_O(pc), .INSTR_O(instr),
		.INSTR_VALID_O(ivalid), .TBL_REQ_I(tbl_req), .TBL_REQ_DATA_I(tbl_data),
		.TBL_BUSY_O(busy), .TBL_DONE_O(done), .DM_WE_O(dm_we), .DM_WR_O(dm_wr),
		.TABLE_HIGH_BYTE_LATCH_WE_I(th_we), .TABLE_HIGH_BYTE_LATCH_WDATA_I(th_wd), .TABLE_HIGH_BYTE_LATCH_O(table_high_byte_latch), .PROG_MODE_I(prog),
		.PROG_SERIAL_CLOCK_PIN_I(sck), .PROG_SERIAL_DATA_PIN_I(pin),
		.PROG_SERIAL_DATA_PIN_O(dout), .PROG_SERIAL_DATA_PIN_OE_O(oe), .EE_WE_O(ee_we),
		.EE_RE_O(ee_re), .EE_ADDR_O(ee_addr), .EE_WDATA_O(ee_wd), .EE_RDATA_I(ee_rd));
	pmtr_writer_model wr (.clk_i(clk), .pin_i(pin), .ck_o(sck), .da_o(sda));
	task automatic results();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [26:0] exp, input logic [26:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// hang guard, far above the few thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end
	// each write-back takes the oldest note
	always @(negedge clk) begin
		if (dm_we === 1'b1) chk("table write", expq.pop_front(), {dm_wr, table_high_byte_latch});
		if (ee_we === 1'b1) chk("nv write", expq.pop_front(), {3'h0, ee_addr, ee_wd});
		if (ee_re === 1'b1) chk("nv read addr", expq.pop_front(), {3'h0, ee_addr, 8'h00});
	end
	function automatic logic [14:0] addr_of(input logic last, input logic [7:0] lo,
		input logic [7:0] hi);
		return 15'((last ? {7'h7F, lo} : {hi, lo}) & (WORDS - 1));
	endfunction
	task automatic put(input logic [14:0] a, input logic [15:0] d);
		logic [15:0] rd;
		mem[a] = d;
		wr.frame(PMTR_CMD_PM_WRITE, {1'b0, a}, d, rd);
	endtask
	task automatic wait_valid();
		int n;
		n = 0;
		while (ivalid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
	endtask
	// one table read, offered at the first idle T1
	task automatic tbl(input pmtr_tbl_kind_t k, input logic [7:0] lo, input logic [7:0] hi,
		input logic [2:0] sec);
		logic [7:0] off;
		logic [15:0] w;
		int n;
		off = 8'($urandom);
		w = mem[addr_of(k[0], lo, hi)];
		n = 0;
		while (!(phase === PMTR_PH_T1 && busy === 1'b0) && n < 40) begin
			@(negedge clk);
			n++;
		end
		tbl_data = '{k, sec, off, lo, hi};
		tbl_req = 1'b1;
		expq.push_back({k[1] ? sec : PMTR_SECTOR_ZERO, off, w[7:0], w[15:8]});
		@(negedge clk);
		tbl_req = 1'b0;
	endtask
	initial begin
		logic [15:0] rd, w, ea;
		logic [14:0] a;
		logic [7:0] lo [4];
		logic [7:0] hi [4];
		w = 16'($urandom(32'h85D922CC));
		repeat (3) @(negedge clk);
		chk("reset pc", 27'h0, {12'h0, pc});
		chk("reset table_high_byte_latch", 27'h0, {19'h0, table_high_byte_latch});
		@(negedge clk);
		rst_b = 1'b1;
		@(negedge clk);
		chk("first pc", 27'h1, {12'h0, pc});
		// word zero, read back, then a round trip to nv memory
		prog = 1'b1;
		put(15'h0000, w);
		wr.frame(PMTR_CMD_PM_READ, 16'h0000, 16'h0000, rd);
		chk("serial read", {11'h0, w}, {11'h0, rd});
		ee_rd = 8'($urandom);
		ea = 16'($urandom);
		expq.push_back({3'h0, ea, w[7:0]});
		wr.frame(PMTR_CMD_EE_WRITE, ea, w, rd);
		expq.push_back({3'h0, ea, 8'h00});
		wr.frame(PMTR_CMD_EE_READ, ea, 16'h0000, rd);
		chk("nv read", {19'h0, ee_rd}, {19'h0, rd[7:0]});
		// second reset in mid-run must restart at the vector
		prog = 1'b0;
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		chk("reset pc", 27'h0, {12'h0, pc});
		rst_b = 1'b1;
		wait_valid();
		chk("vector word", {11'h0, w}, {11'h0, instr});
		// distinct low pointers keep the four words apart
		prog = 1'b1;
		for (int k = 0; k < 4; k++) begin
			lo[k] = (8'($urandom) & 8'hFC) | 8'(k);
			hi[k] = 8'($urandom);
			put(addr_of(k[0], lo[k], hi[k]), 16'($urandom));
		end
		prog = 1'b0;
		for (int k = 0; k < 4; k++) begin
			tbl(pmtr_tbl_kind_t'(k), lo[k], hi[k], 3'($urandom_range(7, 1)));
		end
		repeat (12) @(negedge clk);
		th_wd = 8'($urandom);
		th_we = 1'b1;
		@(negedge clk);
		th_we = 1'b0;
		chk("table_high_byte_latch write", {19'h0, th_wd}, {19'h0, table_high_byte_latch});
		// jump to a table word and fetch it as code
		a = addr_of(1'b1, lo[3], hi[3]);
		while (phase !== PMTR_PH_T4) @(negedge clk);
		pc_addr = a;
		pc_load = 1'b1;
		@(negedge clk);
		pc_load = 1'b0;
		wait_valid();
		chk("jump fetch", {11'h0, mem[a]}, {11'h0, instr});
		chk("notes left", 27'h0, 27'(expq.size()));
		results();
	end
endmodule
bind pmtr_top pmtr_top_asserts chk_i (.SYS_CLK_I, .RST_B_I, .PHASE_O, .PC_LOAD_I, .PC_O,
	.INSTR_VALID_O, .TBL_REQ_I, .TBL_REQ_DATA_I, .TBL_BUSY_O, .TBL_DONE_O, .DM_WE_O, .DM_WR_O,
	.TABLE_HIGH_BYTE_LATCH_WE_I, .TABLE_HIGH_BYTE_LATCH_WDATA_I, .TABLE_HIGH_BYTE_LATCH_O, .PROG_MODE_I, .PROG_SERIAL_DATA_PIN_OE_O);
